// File: cps_sequencer.sv
// chassis power sequencer: power-up, graceful shutdown, pilot and status lamps
// assumes i_nrst is the power-on reset released when AC mains appear
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
module cps_sequencer
   import cps_pkg::*;
#(
   parameter int unsigned HOLD_CYCLES  = HOLD_CYC,
   parameter int unsigned BLINK_CYCLES = BLINK_CYC,
   parameter int unsigned DB_CYCLES    = DB_CYC,
   parameter int unsigned FAN_CYCLES   = FAN_CYC
) (
   input  wire logic              i_clk,
   input  wire logic              i_nrst,
   input  wire logic              i_button,
   input  wire logic              i_key_unlocked,
   input  wire logic              i_fans_ok,
   input  wire logic              i_fault,
   input  wire logic              i_warn,
   input  wire logic              i_host_off,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [DATA_W-1:0] i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic      [DATA_W-1:0] o_rdata,
   output logic                   o_rails_en,
   output logic                   o_host_shdn,
   output logic                   o_pilot_red,
   output logic                   o_pilot_green,
   output logic                   o_stat_red,
   output logic                   o_stat_green
);

   logic             btn_db;
   logic             key_db;
   cps_state_t       st_q;
   cps_state_t       st_d;
   logic             boot_q;
   logic [CNT_W-1:0] hold_q;
   logic             fired_q;
   logic             hold_hit;
   logic [CNT_W-1:0] tmr_q;
   logic [CNT_W-1:0] blink_cnt_q;
   logic             blink_q;
   logic             fault_q;
   logic             restart_q;
   logic             auto_en_q;
   logic             sw_req;
   logic             go_down;
   logic             auto_go;
   logic [1:0]       pilot_d;
   logic [1:0]       stat_d;

   function automatic logic [1:0] pilot_code(input cps_state_t s, input logic ph,
                                             input logic warn, input logic rst);
      logic [1:0] c;
      c = LAMP_AMBER;
      unique case (s)
         ST_OFF:     c = LAMP_AMBER;
         ST_FLT_OFF: c = ph ? LAMP_RED : LAMP_AMBER;
         ST_UP_FAIL: c = LAMP_RED;
         ST_UP:      c = ph ? LAMP_RED : LAMP_DARK;
         ST_ON, ST_SHDN: begin
            if (rst) begin
               c = ph ? LAMP_RED : LAMP_GREEN;
            end else if (warn) begin
               c = ph ? LAMP_RED : LAMP_DARK;
            end else begin
               c = LAMP_GREEN;
            end
         end
         default:    c = LAMP_AMBER;
      endcase
      return c;
   endfunction

   cps_debounce #(
      .STABLE_CYC (DB_CYCLES)
   ) u_db_btn (
      .i_clk   (i_clk),
      .i_nrst  (i_nrst),
      .i_raw   (i_button),
      .o_level (btn_db)
   );

   cps_debounce #(
      .STABLE_CYC (DB_CYCLES)
   ) u_db_key (
      .i_clk   (i_clk),
      .i_nrst  (i_nrst),
      .i_raw   (i_key_unlocked),
      .o_level (key_db)
   );

   // hold timer: only an unlocked, unbroken press ever reaches the end
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         hold_q <= '0;
      end else if (!btn_db || !key_db || fired_q) begin
         hold_q <= '0;
      end else begin
         hold_q <= hold_q + 32'h1;
      end
   end

   assign hold_hit = btn_db && key_db && !fired_q && hold_q == CNT_W'(HOLD_CYCLES - 1);

   // one action per press; a held button must be released before the next
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         fired_q <= 1'b0;
      end else if (!btn_db) begin
         fired_q <= 1'b0;
      end else if (hold_hit) begin
         fired_q <= 1'b1;
      end
   end

   // shared blink phase for every flashing pattern
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         blink_cnt_q <= '0;
         blink_q     <= 1'b0;
      end else if (blink_cnt_q == CNT_W'(BLINK_CYCLES - 1)) begin
         blink_cnt_q <= '0;
         blink_q     <= !blink_q;
      end else begin
         blink_cnt_q <= blink_cnt_q + 32'h1;
      end
   end

   // software bits; a shutdown write only counts while the key is unlocked
   assign sw_req = i_wr && i_addr == REG_CTRL && i_wdata[CTRL_SHDN_BIT] && key_db;

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         auto_en_q <= CTRL_AUTO_RST;
      end else if (i_wr && i_addr == REG_CTRL) begin
         auto_en_q <= i_wdata[CTRL_AUTO_BIT];
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_rdata <= '0;
      end else if (i_rd && i_addr == REG_CTRL) begin
         o_rdata <= DATA_W'({auto_en_q, 1'b0});
      end else if (i_rd && i_addr == REG_STATUS) begin
         o_rdata <= DATA_W'({fault_q, restart_q, key_db, btn_db, st_q});
      end else begin
         o_rdata <= '0;
      end
   end

   // fault always wins; button and software need the key (hold_hit already does)
   assign go_down = i_fault || hold_hit || sw_req;
   assign auto_go = auto_en_q && !i_fault;

   always_comb begin
      st_d = st_q;
      unique case (st_q)
         ST_OFF: begin
            if (boot_q || hold_hit) begin
               st_d = ST_UP;
            end
         end
         ST_FLT_OFF: begin
            if (hold_hit || auto_go) begin
               st_d = ST_UP;
            end
         end
         ST_UP: begin
            if (i_fault || tmr_q == CNT_W'(FAN_CYCLES - 1)) begin
               st_d = ST_UP_FAIL;
            end else if (i_fans_ok) begin
               st_d = ST_ON;
            end
         end
         ST_ON: begin
            if (go_down) begin
               st_d = ST_SHDN;
            end
         end
         ST_SHDN: begin
            if (i_host_off) begin
               st_d = fault_q ? ST_FLT_OFF : ST_OFF;
            end
         end
         ST_UP_FAIL: begin
            if (tmr_q == CNT_W'(BLINK_CYCLES - 1)) begin
               st_d = ST_OFF;
            end
         end
         default: st_d = ST_OFF;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_q <= ST_OFF;
      end else begin
         st_q <= st_d;
      end
   end

   // power-on reset means AC just appeared, so the first pass starts up
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         boot_q <= 1'b1;
      end else if (st_q != ST_OFF) begin
         boot_q <= 1'b0;
      end
   end

   // state timer for fan wait and failure display
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         tmr_q <= '0;
      end else if (st_d != st_q) begin
         tmr_q <= '0;
      end else begin
         tmr_q <= tmr_q + 32'h1;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         fault_q <= 1'b0;
      end else if (st_q == ST_ON && i_fault) begin
         fault_q <= 1'b1;
      end else if (st_q == ST_FLT_OFF && st_d == ST_UP) begin
         fault_q <= 1'b0;
      end
   end

   // unattended restart is recorded until the state next enters ST_OFF or ST_FLT_OFF
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         restart_q <= 1'b0;
      end else if (st_q == ST_FLT_OFF && st_d == ST_UP) begin
         restart_q <= !hold_hit;
      end else if (st_d == ST_OFF || st_d == ST_FLT_OFF) begin
         restart_q <= 1'b0;
      end
   end

   // lamps follow the next state so they change in step with st_q
   assign pilot_d = pilot_code(st_d, blink_q, i_warn, restart_q);
   assign stat_d  = st_d == ST_SHDN ? LAMP_RED :
                    (st_d == ST_ON || st_d == ST_UP) ? LAMP_GREEN : LAMP_AMBER;

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_pilot_red   <= 1'b0;
         o_pilot_green <= 1'b0;
         o_stat_red    <= 1'b0;
         o_stat_green  <= 1'b0;
      end else begin
         o_pilot_red   <= pilot_d[1];
         o_pilot_green <= pilot_d[0];
         o_stat_red    <= stat_d[1];
         o_stat_green  <= stat_d[0];
      end
   end

   // rails stay on through the whole shutdown wait; no timeout by design
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_rails_en  <= 1'b0;
         o_host_shdn <= 1'b0;
      end else begin
         o_rails_en  <= st_d == ST_UP || st_d == ST_ON || st_d == ST_SHDN;
         o_host_shdn <= st_d == ST_SHDN;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   sequence s_down_start;
      st_q == ST_ON && go_down;
   endsequence

   sequence s_in_shdn;
      st_q == ST_SHDN && o_stat_red && !o_stat_green && o_host_shdn && o_rails_en;
   endsequence

   // sampled reset keeps the release edge itself out of the antecedent
   property p_autostart;
      i_nrst && st_q == ST_OFF && boot_q |=> st_q == ST_UP && o_rails_en;
   endproperty
   a_autostart: assert property (p_autostart) else $error("no automatic power-up");

   property p_short_press;
      st_q == ST_OFF && !boot_q && !btn_db |=> st_q == ST_OFF && hold_q == '0;
   endproperty
   a_short_press: assert property (p_short_press) else $error("released press acted");

   property p_locked;
      !key_db |=> hold_q == '0 && !hold_hit;
   endproperty
   a_locked: assert property (p_locked) else $error("button used while locked");

   property p_sw_locked;
      st_q == ST_ON && !key_db && !i_fault && i_wr |=> st_q == ST_ON;
   endproperty
   a_sw_locked: assert property (p_sw_locked) else $error("locked shutdown honoured");

   property p_green;
      st_q == ST_ON && !i_warn && !restart_q && !go_down
         |-> ##1 o_pilot_green && !o_pilot_red;
   endproperty
   a_green: assert property (p_green) else $error("pilot not green");

   property p_amber_off;
      st_q == ST_OFF && !boot_q && !hold_hit |=> o_pilot_red && o_pilot_green && !o_rails_en;
   endproperty
   a_amber_off: assert property (p_amber_off) else $error("off lamp not amber");

   property p_shdn_start;
      s_down_start |=> s_in_shdn;
   endproperty
   a_shdn_start: assert property (p_shdn_start) else $error("shutdown start wrong");

   property p_host_wait;
      st_q == ST_SHDN && !i_host_off [*8] |=> st_q == ST_SHDN && o_rails_en;
   endproperty
   a_host_wait: assert property (p_host_wait) else $error("power dropped early");

   property p_rails_off;
      st_q == ST_SHDN && i_host_off
         |=> !o_rails_en && o_stat_red && o_stat_green && (fault_q == $past(fault_q));
   endproperty
   a_rails_off: assert property (p_rails_off) else $error("rails not removed");

   property p_fault_down;
      st_q == ST_ON && i_fault |=> st_q == ST_SHDN ##0 fault_q;
   endproperty
   a_fault_down: assert property (p_fault_down) else $error("fault did not shut down");

endmodule

// File: cps_pkg.sv
// package for the chassis power sequencer: timing, encodings, register map
// assumes a single free-running 50 MHz clock
package cps_pkg;

   localparam int unsigned CLK_HZ      = 50_000_000;
   localparam int unsigned CYC_PER_MS  = CLK_HZ / 1000;

   // times in milliseconds, counts derived from the clock rate
   localparam int unsigned HOLD_MS     = 6000;
   localparam int unsigned BLINK_MS    = 500;
   localparam int unsigned DEBOUNCE_MS = 10;
   localparam int unsigned FAN_WAIT_MS = 10000;
   localparam int unsigned HOLD_CYC    = HOLD_MS * CYC_PER_MS;
   localparam int unsigned BLINK_CYC   = BLINK_MS * CYC_PER_MS;
   localparam int unsigned DB_CYC      = DEBOUNCE_MS * CYC_PER_MS;
   localparam int unsigned FAN_CYC     = FAN_WAIT_MS * CYC_PER_MS;

   localparam int CNT_W  = 32;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   // register map
   localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
   localparam logic [ADDR_W-1:0] REG_STATUS = 4'h1;
   localparam int CTRL_SHDN_BIT = 0;
   localparam int CTRL_AUTO_BIT = 1;
   localparam logic CTRL_AUTO_RST = 1'b0;

   typedef enum logic [2:0] {
      ST_OFF     = 3'h0,
      ST_UP      = 3'h1,
      ST_ON      = 3'h2,
      ST_SHDN    = 3'h3,
      ST_FLT_OFF = 3'h4,
      ST_UP_FAIL = 3'h5
   } cps_state_t;

   // lamp codes {red, green}; amber lights both
   localparam logic [1:0] LAMP_DARK  = 2'h0;
   localparam logic [1:0] LAMP_GREEN = 2'h1;
   localparam logic [1:0] LAMP_RED   = 2'h2;
   localparam logic [1:0] LAMP_AMBER = 2'h3;

endpackage

// File: cps_debounce.sv
// debouncer for one slow operator contact
// assumes the input is already synchronous to i_clk
`timescale 1ns/1ps
module cps_debounce
   import cps_pkg::*;
#(
   parameter int unsigned STABLE_CYC = DB_CYC
) (
   input  wire logic i_clk,
   input  wire logic i_nrst,
   input  wire logic i_raw,
   output logic      o_level
);

   logic [CNT_W-1:0] cnt_q;
   logic             lvl_q;

   // the level only follows after the input has held for the whole window
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt_q <= '0;
      end else if (i_raw == lvl_q) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + 32'h1;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         lvl_q <= 1'b0;
      end else if (i_raw != lvl_q && cnt_q >= CNT_W'(STABLE_CYC - 1)) begin
         lvl_q <= i_raw;
      end
   end

   assign o_level = lvl_q;

endmodule

// File: cps_host_model.sv
// behavioural host PC on the far side of the shutdown handshake
// assumes the host is unpowered whenever the rails are off
`timescale 1ns/1ps
module cps_host_model #(
   parameter int DELAY = 6
) (
   input  wire logic i_clk,
   input  wire logic i_nrst,
   input  wire logic i_host_shdn,
   input  wire logic i_rails_en,
   input  wire logic i_hang,
   output logic      o_host_off
);
   logic [7:0] cnt_q;

   // a hung host never reports completion, so the chassis must wait
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt_q      <= 8'h0;
         o_host_off <= 1'b0;
      end else if (!i_rails_en) begin
         cnt_q      <= 8'h0;
         o_host_off <= 1'b1;
      end else if (i_host_shdn && !i_hang) begin
         cnt_q <= cnt_q + 8'h1;
         if (cnt_q == 8'(DELAY)) begin
            o_host_off <= 1'b1;
         end
      end else if (!i_host_shdn) begin
         cnt_q      <= 8'h0;
         o_host_off <= 1'b0;
      end
   end
endmodule

// File: tb.sv
// self-checking bench for the chassis power sequencer
// assumes shortened counts and the host model on the shutdown handshake
`timescale 1ns/1ps
module tb
   import cps_pkg::*;
;
   localparam int HOLD = 20;
   localparam int BLINK = 4;
   localparam int DB = 2;
   localparam int FAN = 50;
   logic clk = 1'b0, nrst, button, key, fans, fault, warn, hang, wr, rd;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata;
   logic rails, host_shdn, p_red, p_green, s_red, s_green, host_off;
   int fail_count = 0, n_tests = 0, cycles = 0, n;
   logic [3:0] m;
   logic [7:0] d;

   always #10 clk = ~clk;

   cps_sequencer #(.HOLD_CYCLES(HOLD), .BLINK_CYCLES(BLINK), .DB_CYCLES(DB),
      .FAN_CYCLES(FAN)) cps_sequencer_i (
      .i_clk(clk), .i_nrst(nrst), .i_button(button), .i_key_unlocked(key),
      .i_fans_ok(fans), .i_fault(fault), .i_warn(warn), .i_host_off(host_off),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .o_rails_en(rails), .o_host_shdn(host_shdn), .o_pilot_red(p_red),
      .o_pilot_green(p_green), .o_stat_red(s_red), .o_stat_green(s_green));

   cps_host_model cps_host_model_i (
      .i_clk(clk), .i_nrst(nrst), .i_host_shdn(host_shdn), .i_rails_en(rails),
      .i_hang(hang), .o_host_off(host_off));

   task automatic close_out();
      $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 10000) begin
         fail_count++;
         $display("run did not finish in time");
         close_out();
      end
   end

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic reg_rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask

   task automatic wait_state(input logic [2:0] s);
      int i;
      logic [7:0] v;
      v = 8'h0;
      for (i = 0; i < 100; i++) begin
         reg_rd(REG_STATUS, v);
         if (v[2:0] === s) break;
      end
      check("state", s, v[2:0]);
   endtask

   // sel 0 watches the rails, sel 1 the host request
   task automatic wait_sig(input int sel, input logic v, output int k);
      k = 0;
      while ((sel == 0 ? rails : host_shdn) !== v && k < 100) begin
         @(posedge clk);
         #1;
         k++;
      end
   endtask

   // one bit per lamp combination seen, indexed by {red, green}
   task automatic pilot_mask(output logic [3:0] mk);
      mk = 4'h0;
      repeat (4 * BLINK) begin
         @(posedge clk);
         #1;
         mk = mk | (4'h1 << {p_red, p_green});
      end
   endtask

   task automatic set_key(input logic v);
      @(posedge clk);
      key <= v;
      repeat (DB + 3) @(posedge clk);
   endtask

   task automatic power_on();
      @(posedge clk);
      button <= 1'b1;
      wait_sig(0, 1'b1, n);
      @(posedge clk);
      button <= 1'b0;
      check("hold length", 1'h1, n >= HOLD);
   endtask

   task automatic t_auto_up();
      wait_sig(0, 1'b1, n);
      check("auto power-up", 1'h1, rails);
      pilot_mask(m);
      check("alarm pilot", 4'h5, m);
      @(posedge clk);
      fans <= 1'b1;
      wait_state(ST_ON);
      pilot_mask(m);
      check("on pilot", 4'h2, m);
      @(posedge clk);
      warn <= 1'b1;
      pilot_mask(m);
      check("warn pilot", 4'h5, m);
      @(posedge clk);
      warn <= 1'b0;
      $display("test auto_up done");
   endtask

   task automatic t_sw_shdn();
      set_key(1'b0);
      reg_wr(REG_CTRL, 8'h01);
      repeat (4) @(posedge clk);
      #1;
      check("locked sw request", 1'h0, host_shdn);
      hang <= 1'b1;
      set_key(1'b1);
      reg_wr(REG_CTRL, 8'h01);
      #1;
      check("host request", 1'h1, host_shdn);
      check("status red first", 2'h2, {s_red, s_green});
      check("rails during wait", 1'h1, rails);
      repeat (200) @(posedge clk);
      #1;
      check("rails with hung host", 1'h1, rails);
      hang <= 1'b0;
      wait_sig(0, 1'b0, n);
      check("host done first", 1'h1, n >= 6);
      check("status amber", 2'h3, {s_red, s_green});
      wait_state(ST_OFF);
      pilot_mask(m);
      check("off pilot", 4'h8, m);
      $display("test sw_shdn done");
   endtask

   task automatic t_button();
      @(posedge clk);
      button <= 1'b1;
      repeat (10) @(posedge clk);
      button <= 1'b0;
      repeat (30) @(posedge clk);
      reg_rd(REG_STATUS, d);
      check("short press", {1'h0, ST_OFF}, {rails, d[2:0]});
      set_key(1'b0);
      @(posedge clk);
      button <= 1'b1;
      repeat (40) @(posedge clk);
      button <= 1'b0;
      repeat (5) @(posedge clk);
      #1;
      check("locked press", 1'h0, rails);
      set_key(1'b1);
      power_on();
      wait_state(ST_ON);
      $display("test button done");
   endtask

   task automatic t_hold_off();
      @(posedge clk);
      button <= 1'b1;
      wait_sig(1, 1'b1, n);
      @(posedge clk);
      button <= 1'b0;
      check("hold to shut down", 1'h1, n >= HOLD);
      wait_state(ST_OFF);
      $display("test hold_off done");
   endtask

   task automatic t_fault();
      power_on();
      wait_state(ST_ON);
      @(posedge clk);
      fault <= 1'b1;
      wait_sig(1, 1'b1, n);
      check("fault shutdown prompt", 1'h1, n <= 3);
      wait_sig(0, 1'b0, n);
      wait_state(ST_FLT_OFF);
      pilot_mask(m);
      check("fault-off pilot", 4'hc, m);
      $display("test fault done");
   endtask

   task automatic t_restart();
      reg_wr(REG_CTRL, 8'h02);
      reg_rd(REG_CTRL, d);
      check("ctrl readback", 8'h02, d);
      reg_rd(4'h7, d);
      check("unmapped read", 8'h00, d);
      @(posedge clk);
      fault <= 1'b0;
      wait_sig(0, 1'b1, n);
      wait_state(ST_ON);
      pilot_mask(m);
      check("restart pilot", 4'h6, m);
      reg_rd(REG_STATUS, d);
      check("restart flag", 1'h1, d[5]);
      reg_wr(REG_CTRL, 8'h01);
      wait_state(ST_OFF);
      $display("test restart done");
   endtask

   task automatic t_up_fail();
      @(posedge clk);
      fans <= 1'b0;
      power_on();
      wait_sig(0, 1'b0, n);
      // counted from one edge after the rails rose, so one short of the full wait
      check("fan wait", 1'h1, n == FAN - 1);
      check("fail pilot red", 2'h2, {p_red, p_green});
      wait_state(ST_OFF);
      pilot_mask(m);
      check("fail pilot amber", 4'h8, m);
      $display("test up_fail done");
   endtask

   initial begin
      {button, fans, fault, warn, hang, wr, rd} = '0;
      key = 1'b1;
      addr = '0;
      wdata = '0;
      nrst = 1'b0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      t_auto_up();
      t_sw_shdn();
      t_button();
      t_hold_off();
      t_fault();
      t_restart();
      t_up_fail();
      close_out();
   end
endmodule
